// *** bench/host_model.sv ***
// Host processor model that issues register reads
`timescale 1ns/1ps
module host_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       valid_in,
  output logic            rd_out,
  output logic      [7:0] addr_out
);
  initial begin
    rd_out = 1'b0;
    addr_out = 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  // One-cycle strobe; address is scrambled on release so a stale value never helps
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge mclk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge mclk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
    v = valid_in;
  endtask
endmodule // host_model

// *** bench/path_alarm_interrupt_status_test.sv ***
// Random and corner test of the path event status register
`timescale 1ns/1ps
module path_alarm_interrupt_status_test;
  logic       mclk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [7:0] status_in = 8'h00;
  logic [7:0] enable_in = 8'h00;
  logic [7:0] addr_w, rdata_w, exp_reg, d, st;
  logic       rd_w, valid_w, v;
  int         n_errors = 0, samples_checked = 0, cyc = 0;
  always #10 mclk_in = ~mclk_in;
  path_alarm_interrupt_status dut (.mclk_in(mclk_in), .rst_in(rst_in), .status_in(status_in),
    .enable_in(enable_in), .addr_in(addr_w), .rd_in(rd_w), .rdata_out(rdata_w), .rdata_valid_out(valid_w));
  host_model host (.mclk_in(mclk_in), .rdata_in(rdata_w), .valid_in(valid_w), .rd_out(rd_w), .addr_out(addr_w));
  ////////////////////////////////////////////////////////////////
  // Events predicted for one status step with enables held steady
  function automatic logic [7:0] events(logic [7:0] o, logic [7:0] n, logic [7:0] e);
    return e & path_event_pkg::USED_BITS_MASK & (((o ^ n) & path_event_pkg::DUAL_EVENT_MASK)
      | (~o & n & ~path_event_pkg::DUAL_EVENT_MASK));
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic check_valid(input logic got);
    samples_checked++;
    if (got !== 1'b1) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, 1'b1);
    end
  endtask
  task automatic final_report;
    $display("errors=%0d checked=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Five cycles cover the two-flop sync plus the latch stage
  task automatic step(input logic [7:0] n, input logic [7:0] e);
    @(posedge mclk_in);
    status_in <= n;
    enable_in <= e;
    exp_reg = exp_reg | events(st, n, e);
    st = n;
    repeat (5) @(posedge mclk_in);
  endtask
  // Unmapped reads answer zero and must leave the latch alone
  task automatic rd_check(input logic [7:0] a);
    host.read(a, d, v);
    check_valid(v);
    check(d, (a == path_event_pkg::STATUS_OFFSET) ? exp_reg : 8'h00);
    if (a == path_event_pkg::STATUS_OFFSET) exp_reg = 8'h00;
  endtask
  // Event latches on the very edge that the clearing read is taken: old bits out, new bits kept
  task automatic race_check(input logic [7:0] n, input logic [7:0] e);
    @(posedge mclk_in);
    status_in <= n;
    enable_in <= e;
    @(posedge mclk_in);
    host.read(path_event_pkg::STATUS_OFFSET, d, v);
    check_valid(v);
    check(d, exp_reg);
    exp_reg = events(st, n, e);
    st = n;
    repeat (5) @(posedge mclk_in);
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence: corners first, then random steps and reads
  initial begin
    void'($urandom(32'h68cf5430));
    exp_reg = 8'h00;
    st = 8'h00;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_check(8'h3f);
    step(8'hff, 8'hff);
    rd_check(8'h3f);
    step(8'h00, 8'hff);
    rd_check(8'h3e);
    rd_check(8'h3f);
    rd_check(8'h3f);
    step(8'hff, 8'h00);
    rd_check(8'h3f);
    race_check(8'h00, 8'hff);
    rd_check(8'h3f);
    repeat (300) begin
      step(8'($urandom), 8'($urandom));
      if ($urandom_range(1, 0)) rd_check($urandom_range(1, 0) ? 8'h3f : 8'($urandom));
      if ($urandom_range(7, 0) == 0) race_check(8'($urandom), 8'($urandom));
    end
    rd_check(8'h3f);
    final_report();
  end
  // Hang guard sized well above the planned run
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
endmodule // path_alarm_interrupt_status_test

// *** core/edge_event_detect.sv ***
// Edge detector for one status bit, single or dual event
`timescale 1ns/1ps
module edge_event_detect #(
  parameter bit DUAL = 1'b0
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  input  wire logic enable_in,
  output logic      event_out
);
  logic prev_reg;

  // Remember last synchronised level
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end

  // Enable gates the event, not the history, so no false edge when enabled
  always_comb begin
    if (DUAL) begin
      event_out = enable_in & (level_in ^ prev_reg);
    end else begin
      event_out = enable_in & level_in & ~prev_reg;
    end
  end
endmodule // edge_event_detect

// *** core/path_alarm_interrupt_status.sv ***
// Receive path event status register, clear on read
`timescale 1ns/1ps
module path_alarm_interrupt_status (
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] status_in,
  input  wire logic [7:0] enable_in,
  input  wire logic [7:0] addr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            rdata_valid_out
);
  logic [7:0] sync_level;
  logic [7:0] event_hit;
  logic [7:0] event_reg;
  logic [7:0] event_next;
  logic       hit_read;

  //////////////////////////////////////////////////////////////////////////////
  // Status levels come from detectors possibly on other timing, so synchronise
  genvar gi;
  generate
    for (gi = 1; gi < path_event_pkg::STATUS_WIDTH; gi++) begin : g_bit
      status_sync u_sync (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .level_in  (status_in[gi]),
        .level_out (sync_level[gi])
      );
      // Dual/single kind per bit from the package mask
      edge_event_detect #(
        .DUAL (path_event_pkg::DUAL_EVENT_MASK[gi])
      ) u_edge (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .level_in  (sync_level[gi]),
        .enable_in (enable_in[gi]),
        .event_out (event_hit[gi])
      );
    end
  endgenerate

  // Reserved bit never produces an event
  assign sync_level[path_event_pkg::BIT_RESERVED] = 1'b0;
  assign event_hit[path_event_pkg::BIT_RESERVED]  = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Clearing read; a new event in the read cycle wins over the clear
  assign hit_read = rd_in && (addr_in == path_event_pkg::STATUS_OFFSET);

  always_comb begin
    if (hit_read) begin
      event_next = event_hit;
    end else begin
      event_next = event_reg | event_hit;
    end
    event_next = event_next & path_event_pkg::USED_BITS_MASK;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      event_reg <= path_event_pkg::STATUS_RESET;
    end else begin
      event_reg <= event_next;
    end
  end

  // Read data registered; unmapped addresses return zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rdata_out       <= 8'h00;
      rdata_valid_out <= 1'b0;
    end else begin
      rdata_valid_out <= rd_in;
      rdata_out       <= hit_read ? event_reg : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_RESERVED_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
    rdata_out[0] == 1'b0 && event_reg[0] == 1'b0)
    else $error("Reserved bit not zero");

  AST_READ_RETURNS: assert property (@(posedge mclk_in) disable iff (rst_in)
    hit_read |=> rdata_valid_out && rdata_out == $past(event_reg))
    else $error("Read did not return latched bits");

  AST_READ_CLEARS: assert property (@(posedge mclk_in) disable iff (rst_in)
    hit_read && event_hit == 8'h00 |=> event_reg == 8'h00)
    else $error("Read did not clear bits");

  AST_SET_WINS: assert property (@(posedge mclk_in) disable iff (rst_in)
    hit_read && event_hit[7] |=> event_reg[7])
    else $error("Event lost during clearing read");

  AST_ALARM_FALL: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[7] && $fell(sync_level[7]) |=> event_reg[7])
    else $error("Dual event falling edge missed");

  // A falling edge on a single-event bit must leave a clear latch clear
  AST_PARITY_NO_FALL: assert property (@(posedge mclk_in) disable iff (rst_in)
    !hit_read && !event_reg[5] && $fell(sync_level[5]) |=> !event_reg[5])
    else $error("Single event set on falling edge");

  AST_PARITY_RISE: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[5] && $rose(sync_level[5]) |=> event_reg[5])
    else $error("Parity rising edge missed");

  AST_DISABLED_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in == 8'h00 && !hit_read |=> event_reg == $past(event_reg))
    else $error("Bit set while disabled");

  AST_LABEL_DUAL: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[3] && $changed(sync_level[3]) |=> event_reg[3])
    else $error("Label mismatch change missed");

  // Per-bit kind checks for the remaining mapped bits
  AST_REMOTE_DUAL: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[6] && $changed(sync_level[6]) |=> event_reg[6])
    else $error("Remote defect change missed");

  AST_FAR_BLOCK_RISE: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[4] && $rose(sync_level[4]) |=> event_reg[4])
    else $error("Far block error rising edge missed");

  AST_FAR_BLOCK_NO_FALL: assert property (@(posedge mclk_in) disable iff (rst_in)
    !hit_read && !event_reg[4] && $fell(sync_level[4]) |=> !event_reg[4])
    else $error("Far block error set on falling edge");

  AST_UNEQUIPPED_DUAL: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[2] && $changed(sync_level[2]) |=> event_reg[2])
    else $error("Unequipped change missed");

  AST_TRACE_RISE: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in[1] && $rose(sync_level[1]) |=> event_reg[1])
    else $error("Trace change rising edge missed");

  AST_TRACE_NO_FALL: assert property (@(posedge mclk_in) disable iff (rst_in)
    !hit_read && !event_reg[1] && $fell(sync_level[1]) |=> !event_reg[1])
    else $error("Trace change set on falling edge");

  // Answer pulse follows every strobe; idle cycles show zero data
  AST_VALID_PULSE: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_in |=> rdata_valid_out)
    else $error("Read strobe without valid pulse");

  AST_IDLE_ZERO: assert property (@(posedge mclk_in) disable iff (rst_in)
    !rd_in |=> !rdata_valid_out && rdata_out == 8'h00)
    else $error("Read answer without strobe");

  // Unmapped reads answer zero and must not clear anything
  AST_UNMAPPED_KEEP: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_in && !hit_read |=> rdata_out == 8'h00 && event_reg == ($past(event_reg) | $past(event_hit)))
    else $error("Unmapped read disturbed status");
endmodule // path_alarm_interrupt_status

// *** core/path_event_pkg.sv ***
// Constants for the receive path event status register block
package path_event_pkg;
  localparam int          STATUS_WIDTH      = 8;
  localparam logic [7:0]  STATUS_OFFSET     = 8'h3f;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  // Bit positions inside the status byte
  localparam int          BIT_ALARM_SIGNAL  = 7;
  localparam int          BIT_REMOTE_DEFECT = 6;
  localparam int          BIT_PARITY_ERROR  = 5;
  localparam int          BIT_FAR_BLOCK_ERR = 4;
  localparam int          BIT_LABEL_MISMATCH = 3;
  localparam int          BIT_UNEQUIPPED    = 2;
  localparam int          BIT_TRACE_CHANGE  = 1;
  localparam int          BIT_RESERVED      = 0;
  // Per-bit kind: 1 = dual event (either edge), 0 = single event (rising edge)
  localparam logic [7:0]  DUAL_EVENT_MASK   = 8'hcc;
  // Reserved bits always read zero
  localparam logic [7:0]  USED_BITS_MASK    = 8'hfe;
endpackage

// *** core/status_sync.sv ***
// Two-flop synchroniser for one status level
`timescale 1ns/1ps
module status_sync (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  output logic      level_out
);
  logic meta_reg;

  // First flop feeds only the second
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_reg  <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta_reg  <= level_in;
      level_out <= meta_reg;
    end
  end
endmodule // status_sync
